// [hdl/iaip_defines.vh]
`ifndef IAIP_DEFINES_VH
`define IAIP_DEFINES_VH
// Device variants.
`define IAIP_VAR_16IN 2'h0
`define IAIP_VAR_16OUT 2'h1
`define IAIP_VAR_MIXED 2'h2
// Assembly instance numbers.
`define IAIP_INST_OUT 8'h64
`define IAIP_INST_DIAG 8'h65
`define IAIP_INST_NODIAG 8'h66
// Image lengths in bytes.
`define IAIP_LEN_NODIAG 4'h3
`define IAIP_LEN_16IN 4'h4
`define IAIP_LEN_16OUT 4'h7
`define IAIP_LEN_MIXED 4'h6
`define IAIP_LEN_OUT 4'h2
// Module information byte fields.
`define IAIP_SENSOR_SUPPLY_LOW_FLAG 0
`define IAIP_ACTUATOR_SUPPLY_LOW_FLAG 1
`define IAIP_ANY_SENSOR_SHORT_FLAG 2
`define IAIP_ACTUATOR_SHORT_FLAG 3
// APB register byte offsets.
`define IAIP_REG_CTRL 12'h000
`define IAIP_REG_STATUS 12'h004
`define IAIP_REG_IRQ_STAT 12'h008
`define IAIP_REG_IRQ_EN 12'h00c
`define IAIP_REG_IRQ_CLR 12'h010
`define IAIP_REG_IMAGE_LO 12'h014
`define IAIP_REG_IMAGE_HI 12'h018
`define IAIP_REG_TARGET 12'h01c
// Control register fields and reset value.
`define IAIP_CTRL_INST_LSB 0
`define IAIP_CTRL_RST 32'h00000065
// Interrupt status bits.
`define IAIP_IRQ_INCHG 0
`define IAIP_IRQ_DIAG 1
`define IAIP_IRQ_CE 2
`define IAIP_IRQ_BADINST 3
`define IAIP_IRQ_W 4
`endif

// [hdl/iaip_packer.v]
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "iaip_defines.vh"
// How it works
// - diagnostic bytes follow the process input bytes
// - first diagnostic byte is module information
// - instance 101 selects image with diagnostics
// - instance 102 stops after module information byte
// - input bits show sampled actual channel state
// - 16-in packs A even, B odd, ports 1-8
// - 16-in info byte: bit0 supply low, bit2 short
// - 16-in byte 3 holds per-port sensor shorts
// - 16-out bytes 0-1 show actual output states
// - 16-out info byte bits 0,1,3; upper zero
// - 16-out bytes 3,4 zero, then channel faults
// - output image two bytes drives channel targets
// - mixed byte 0 inputs, byte 1 actual outputs
// - mixed info byte carries four flags, upper zero
// - mixed byte 3 shorts, byte 4 zero, byte 5 faults
//////////////////////////////////////////////////////////////////////////////
module iaip_packer #(
  parameter VARIANT = 0
) (
  // Clock and reset.
  input wire CORE_CLK,
  input wire ARST_N,
  // APB slave.
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output wire PSLVERR,
  output reg [31:0] PRDATA,
  // Channel pins, sampled; A is pin 4, B is pin 2, bit n-1 is port n.
  input wire [7:0] PORT_CHANNEL_A_STATE,
  input wire [7:0] PORT_CHANNEL_B_STATE,
  input wire [7:0] PORT_SENSOR_SHORT_FLAG,
  input wire [7:0] CHAN_A_FAULT_FLAG,
  input wire [7:0] CHAN_B_FAULT_FLAG,
  input wire SENSOR_SUPPLY_LOW_FLAG,
  input wire ACTUATOR_SUPPLY_LOW_FLAG,
  // Output assembly from the network side.
  input wire OUT_IMAGE_VALID,
  input wire [15:0] OUT_IMAGE_DATA,
  // Input image byte read port for the network side.
  input wire [3:0] IMG_BYTE_INDEX,
  output reg [7:0] IMG_BYTE_DATA,
  output reg [3:0] IMG_LENGTH,
  // Output channel drives.
  output reg [15:0] CHAN_TARGET,
  // Interrupt.
  output wire IRQ
);

  localparam NSYNC = 42;

  function [15:0] iaip_pack;
    input [7:0] a;
    input [7:0] b;
    integer i;
    begin
      iaip_pack = 16'h0000;
      for (i = 0; i < 8; i = i + 1) begin
        iaip_pack[2*i] = a[i];
        iaip_pack[2*i+1] = b[i];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a change counts once stages two and three
  // agree, so the first stage is read only by the second.
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  reg [NSYNC-1:0] s3_q;
  reg [NSYNC-1:0] clean_q;
  wire [NSYNC-1:0] raw;
  wire [NSYNC-1:0] agree;

  assign raw = {ACTUATOR_SUPPLY_LOW_FLAG, SENSOR_SUPPLY_LOW_FLAG,
                CHAN_B_FAULT_FLAG, CHAN_A_FAULT_FLAG,
                PORT_SENSOR_SHORT_FLAG, PORT_CHANNEL_B_STATE,
                PORT_CHANNEL_A_STATE};
  assign agree = ~(s2_q ^ s3_q);

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_q <= {NSYNC{1'b0}};
      s2_q <= {NSYNC{1'b0}};
      s3_q <= {NSYNC{1'b0}};
      clean_q <= {NSYNC{1'b0}};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= (s3_q & agree) | (clean_q & ~agree);
    end
  end

  wire [7:0] st_a = clean_q[7:0];
  wire [7:0] st_b = clean_q[15:8];
  wire [7:0] ssc = clean_q[23:16];
  wire [7:0] ce_a = clean_q[31:24];
  wire [7:0] ce_b = clean_q[39:32];
  wire lvs = clean_q[40];
  wire lva = clean_q[41];

  //////////////////////////////////////////////////////////////////////////
  // Image assembly.  Input bits carry the sampled pin level, never the
  // commanded target; on output ports the pin level is the driver readback.
  wire [15:0] state_w = iaip_pack(st_a, st_b);
  wire [15:0] fault_w = iaip_pack(ce_a, ce_b);
  wire any_ssc = |ssc;
  wire any_ce = |fault_w;

  reg [7:0] info_b;
  reg [7:0] diag3;
  reg [7:0] diag4;
  reg [7:0] diag5;
  reg [7:0] diag6;
  reg [3:0] diag_len;

  always @* begin
    info_b = 8'h00;
    diag3 = 8'h00;
    diag4 = 8'h00;
    diag5 = 8'h00;
    diag6 = 8'h00;
    diag_len = `IAIP_LEN_16IN;
    case (VARIANT[1:0])
      `IAIP_VAR_16IN: begin
        info_b[`IAIP_SENSOR_SUPPLY_LOW_FLAG] = lvs;
        info_b[`IAIP_ANY_SENSOR_SHORT_FLAG] = any_ssc;
        diag3 = ssc;
        diag_len = `IAIP_LEN_16IN;
      end
      `IAIP_VAR_16OUT: begin
        info_b[`IAIP_SENSOR_SUPPLY_LOW_FLAG] = lvs;
        info_b[`IAIP_ACTUATOR_SUPPLY_LOW_FLAG] = lva;
        info_b[`IAIP_ACTUATOR_SHORT_FLAG] = any_ce;
        diag5 = fault_w[7:0];
        diag6 = fault_w[15:8];
        diag_len = `IAIP_LEN_16OUT;
      end
      `IAIP_VAR_MIXED: begin
        info_b[`IAIP_SENSOR_SUPPLY_LOW_FLAG] = lvs;
        info_b[`IAIP_ACTUATOR_SUPPLY_LOW_FLAG] = lva;
        info_b[`IAIP_ANY_SENSOR_SHORT_FLAG] = |ssc[3:0];
        info_b[`IAIP_ACTUATOR_SHORT_FLAG] = |fault_w[15:8];
        diag3 = {4'h0, ssc[3:0]};
        diag5 = fault_w[15:8];
        diag_len = `IAIP_LEN_MIXED;
      end
      default: begin
        diag_len = `IAIP_LEN_16IN;
      end
    endcase
  end

  // Byte 1 on the mixed device is port 5 to 8 readback; packing is the
  // same for all variants so one word serves.
  wire [63:0] image_w = {8'h00, diag6, diag5, diag4, diag3,
                         info_b,
                         state_w};

  //////////////////////////////////////////////////////////////////////////
  // Registers.
  reg [7:0] inst_q;
  reg [`IAIP_IRQ_W-1:0] irq_stat_q;
  reg [`IAIP_IRQ_W-1:0] irq_en_q;
  reg [15:0] state_prev_q;
  reg [7:0] diag_prev_q;
  reg any_ce_prev_q;

  wire inst_diag = (inst_q == `IAIP_INST_DIAG);
  wire inst_nodiag = (inst_q == `IAIP_INST_NODIAG);
  wire inst_bad = ~inst_diag & ~inst_nodiag;
  wire [3:0] len_sel = inst_diag ? diag_len :
                       `IAIP_LEN_NODIAG;

  wire wr = PSEL & PENABLE & PWRITE;
  wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire mapped = (PADDR == `IAIP_REG_CTRL) || (PADDR == `IAIP_REG_STATUS) ||
                (PADDR == `IAIP_REG_IRQ_STAT) ||
                (PADDR == `IAIP_REG_IRQ_EN) ||
                (PADDR == `IAIP_REG_IRQ_CLR) ||
                (PADDR == `IAIP_REG_IMAGE_LO) ||
                (PADDR == `IAIP_REG_IMAGE_HI) ||
                (PADDR == `IAIP_REG_TARGET);

  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  wire [`IAIP_IRQ_W-1:0] events;
  assign events[`IAIP_IRQ_INCHG] = (state_w != state_prev_q);
  assign events[`IAIP_IRQ_DIAG] = (info_b != diag_prev_q);
  assign events[`IAIP_IRQ_CE] = any_ce & ~any_ce_prev_q;
  assign events[`IAIP_IRQ_BADINST] = wr & (PADDR == `IAIP_REG_CTRL) &
    (PWDATA[7:0] != `IAIP_INST_DIAG) & (PWDATA[7:0] != `IAIP_INST_NODIAG);

  wire [`IAIP_IRQ_W-1:0] clr = (wr && PADDR == `IAIP_REG_IRQ_CLR) ?
    PWDATA[`IAIP_IRQ_W-1:0] : {`IAIP_IRQ_W{1'b0}};

  assign IRQ = |(irq_stat_q & irq_en_q);

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      inst_q <= `IAIP_INST_DIAG;
      irq_stat_q <= {`IAIP_IRQ_W{1'b0}};
      irq_en_q <= {`IAIP_IRQ_W{1'b0}};
      state_prev_q <= 16'h0000;
      diag_prev_q <= 8'h00;
      any_ce_prev_q <= 1'b0;
      CHAN_TARGET <= 16'h0000;
      PRDATA <= 32'h00000000;
      IMG_BYTE_DATA <= 8'h00;
      IMG_LENGTH <= `IAIP_LEN_NODIAG;
    end else begin
      state_prev_q <= state_w;
      diag_prev_q <= info_b;
      any_ce_prev_q <= any_ce;
      // A new event wins over a clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~clr) | events;
      if (wr && PADDR == `IAIP_REG_CTRL) begin
        inst_q <= PWDATA[`IAIP_CTRL_INST_LSB+7:`IAIP_CTRL_INST_LSB];
      end
      if (wr && PADDR == `IAIP_REG_IRQ_EN) begin
        irq_en_q <= PWDATA[`IAIP_IRQ_W-1:0];
      end
      // Target bits drive the channel with the input image packing.
      if (OUT_IMAGE_VALID) begin
        CHAN_TARGET <= OUT_IMAGE_DATA;
      end
      if (rd_setup) begin
        case (PADDR)
          `IAIP_REG_CTRL: PRDATA <= {24'h000000, inst_q};
          `IAIP_REG_STATUS: PRDATA <= {23'h0, inst_bad, len_sel,
                                       2'h0, VARIANT[1:0]};
          `IAIP_REG_IRQ_STAT: PRDATA <= {28'h0000000, irq_stat_q};
          `IAIP_REG_IRQ_EN: PRDATA <= {28'h0000000, irq_en_q};
          `IAIP_REG_IMAGE_LO: PRDATA <= image_w[31:0];
          `IAIP_REG_IMAGE_HI: PRDATA <= image_w[63:32];
          `IAIP_REG_TARGET: PRDATA <= {16'h0000, CHAN_TARGET};
          default: PRDATA <= 32'h00000000;
        endcase
      end
      // Bytes past the selected length read zero on the byte port, so instance 102
      // leaks no port or channel diagnostics there; the APB image registers are not masked.
      IMG_LENGTH <= len_sel;
      if (IMG_BYTE_INDEX < len_sel && IMG_BYTE_INDEX < 4'h8) begin
        IMG_BYTE_DATA <= image_w[IMG_BYTE_INDEX[2:0]*8 +: 8];
      end else begin
        IMG_BYTE_DATA <= 8'h00;
      end
    end
  end

endmodule

// [verif/iaip_packer_sva.sv]
`timescale 1ns/1ps
module iaip_sva #(parameter VARIANT = 0) (
  // Clock and reset.
  input wire CORE_CLK,
  input wire ARST_N,
  // Channel inputs.
  input wire [7:0] PORT_CHANNEL_A_STATE,
  input wire [7:0] PORT_CHANNEL_B_STATE,
  input wire [7:0] PORT_SENSOR_SHORT_FLAG,
  input wire SENSOR_SUPPLY_LOW_FLAG,
  // Image and target sides.
  input wire OUT_IMAGE_VALID,
  input wire [15:0] OUT_IMAGE_DATA,
  input wire [3:0] IMG_BYTE_INDEX,
  input wire [7:0] IMG_BYTE_DATA,
  input wire [3:0] IMG_LENGTH,
  input wire [15:0] CHAN_TARGET
);
  function automatic [7:0] pk(input [3:0] a, input [3:0] b);
    for (int i = 0; i < 4; i++) begin
      pk[2*i +: 2] = {b[i], a[i]};
    end
  endfunction
  wire [7:0] pa = PORT_CHANNEL_A_STATE;
  wire [7:0] pb = PORT_CHANNEL_B_STATE;
  wire [7:0] ss = PORT_SENSOR_SHORT_FLAG;
  wire [3:0] ix = IMG_BYTE_INDEX;
  wire [7:0] img01 = ix[0] ? pk(pa[7:4], pb[7:4]) : pk(pa[3:0], pb[3:0]);
  wire [7:0] info = {5'h00, |ss, 1'b0, SENSOR_SUPPLY_LOW_FLAG};
  // Seven quiet cycles cover the input synchroniser and the byte register.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  property p_pack;
    (ix < 4'h2 && $stable(ix) && $stable(pa) && $stable(pb))[*7]
    |=> IMG_BYTE_DATA == $past(img01);
  endproperty
  a_pack: assert property (p_pack) else $error("packing wrong");
  property p_info;
    (ix == 4'h2 && $stable(info))[*7] |=> IMG_BYTE_DATA == $past(info);
  endproperty
  a_info: assert property (p_info) else $error("info wrong");
  property p_info_zero;
    ix == 4'h2 |=> IMG_BYTE_DATA[7:3] == 5'h00 && !IMG_BYTE_DATA[1];
  endproperty
  a_info_zero: assert property (p_info_zero) else $error("info");
  property p_short;
    (ix == 4'h3 && IMG_LENGTH == 4'h4 && $stable(ss))[*7]
    |=> IMG_BYTE_DATA == $past(ss);
  endproperty
  a_short: assert property (p_short) else $error("shorts wrong");
  property p_len;
    IMG_LENGTH == 4'h3 || IMG_LENGTH == 4'h4;
  endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_tail;
    (ix >= IMG_LENGTH && $stable(IMG_LENGTH))[*2] |=> IMG_BYTE_DATA == 8'h00;
  endproperty
  a_tail: assert property (p_tail) else $error("tail not zero");
  property p_tgt_load;
    OUT_IMAGE_VALID |=> CHAN_TARGET == $past(OUT_IMAGE_DATA);
  endproperty
  a_tgt_load: assert property (p_tgt_load) else $error("load");
  property p_tgt_hold;
    !OUT_IMAGE_VALID |=> $stable(CHAN_TARGET);
  endproperty
  a_tgt_hold: assert property (p_tgt_hold) else $error("hold");
endmodule

// [verif/iaip_scanner.sv]
`timescale 1ns/1ps
module iaip_scanner (
  // Clock.
  input wire clk,
  // Input image side.
  output reg [3:0] idx,
  input wire [7:0] byte_in,
  // Output image side.
  output reg vld,
  output reg [15:0] dat
);
  initial begin
    idx = 4'h0;
    vld = 1'b0;
    dat = 16'h0000;
  end
  // The index is held long enough for pin changes to reach the byte.
  task automatic get(input [3:0] i, output [7:0] b);
    @(posedge clk);
    idx <= i;
    repeat (8) @(posedge clk);
    @(negedge clk) b = byte_in;
  endtask
  // Data is scrambled once released so a stale latch cannot hide.
  task automatic put(input [15:0] v);
    @(posedge clk);
    vld <= 1'b1;
    dat <= v;
    @(posedge clk);
    vld <= 1'b0;
    dat <= ~v;
    @(posedge clk);
  endtask
endmodule

// [verif/tb_io_assembly_image_packer.sv]
`timescale 1ns/1ps
`include "iaip_defines.vh"
module tb_io_assembly_image_packer;
  reg CORE_CLK = 1'b0;
  reg ARST_N = 1'b0;
  reg PSEL, PENABLE, PWRITE, SENSOR_SUPPLY_LOW_FLAG, ACTUATOR_SUPPLY_LOW_FLAG;
  reg [11:0] PADDR;
  reg [31:0] PWDATA;
  reg [7:0] PORT_CHANNEL_A_STATE, PORT_CHANNEL_B_STATE, PORT_SENSOR_SHORT_FLAG;
  reg [7:0] CHAN_A_FAULT_FLAG, CHAN_B_FAULT_FLAG;
  wire PREADY, PSLVERR, IRQ, OUT_IMAGE_VALID;
  wire [31:0] PRDATA;
  wire [15:0] OUT_IMAGE_DATA, CHAN_TARGET;
  wire [3:0] IMG_BYTE_INDEX, IMG_LENGTH;
  wire [7:0] IMG_BYTE_DATA;
  integer bad_count = 0;
  integer check_count = 0;
  integer cyc = 0;
  reg err;
  iaip_packer #(.VARIANT(0)) iaip_packer_i (
    .CORE_CLK(CORE_CLK),
    .ARST_N(ARST_N),
    .PSEL(PSEL),
    .PENABLE(PENABLE),
    .PWRITE(PWRITE),
    .PADDR(PADDR),
    .PWDATA(PWDATA),
    .PREADY(PREADY),
    .PSLVERR(PSLVERR),
    .PRDATA(PRDATA),
    .PORT_CHANNEL_A_STATE(PORT_CHANNEL_A_STATE),
    .PORT_CHANNEL_B_STATE(PORT_CHANNEL_B_STATE),
    .PORT_SENSOR_SHORT_FLAG(PORT_SENSOR_SHORT_FLAG),
    .CHAN_A_FAULT_FLAG(CHAN_A_FAULT_FLAG),
    .CHAN_B_FAULT_FLAG(CHAN_B_FAULT_FLAG),
    .SENSOR_SUPPLY_LOW_FLAG(SENSOR_SUPPLY_LOW_FLAG),
    .ACTUATOR_SUPPLY_LOW_FLAG(ACTUATOR_SUPPLY_LOW_FLAG),
    .OUT_IMAGE_VALID(OUT_IMAGE_VALID),
    .OUT_IMAGE_DATA(OUT_IMAGE_DATA),
    .IMG_BYTE_INDEX(IMG_BYTE_INDEX),
    .IMG_BYTE_DATA(IMG_BYTE_DATA),
    .IMG_LENGTH(IMG_LENGTH),
    .CHAN_TARGET(CHAN_TARGET),
    .IRQ(IRQ)
  );
  iaip_scanner iaip_scanner_i (.clk(CORE_CLK), .idx(IMG_BYTE_INDEX),
    .byte_in(IMG_BYTE_DATA), .vld(OUT_IMAGE_VALID), .dat(OUT_IMAGE_DATA));
  always #12.5 CORE_CLK = ~CORE_CLK;
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  task chk(input string n, input [31:0] e, input [31:0] g);
    check_count = check_count + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d, output [31:0] r);
    @(posedge CORE_CLK);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask
  // Reference image byte built straight from the pin levels.
  function automatic [7:0] mdl(input int i, input int len);
    logic [7:0] r;
    r = (i == 3) ? PORT_SENSOR_SHORT_FLAG : 8'h00;
    for (int p = 0; p < 4; p++) begin
      if (i < 2) r[2*p +: 2] = {PORT_CHANNEL_B_STATE[4*i+p],
                                 PORT_CHANNEL_A_STATE[4*i+p]};
    end
    if (i == 2) r = {5'h00, |PORT_SENSOR_SHORT_FLAG, 1'b0,
                     SENSOR_SUPPLY_LOW_FLAG};
    return (i >= len) ? 8'h00 : r;
  endfunction
  initial begin
    logic [31:0] r;
    logic [63:0] rv;
    logic [7:0] b;
    int len;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {PORT_CHANNEL_A_STATE, PORT_CHANNEL_B_STATE, PORT_SENSOR_SHORT_FLAG} = '0;
    {CHAN_A_FAULT_FLAG, CHAN_B_FAULT_FLAG} = '0;
    {SENSOR_SUPPLY_LOW_FLAG, ACTUATOR_SUPPLY_LOW_FLAG} = 2'b00;
    rv[31:0] = $urandom(51);
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    apb(1'b0, `IAIP_REG_CTRL, 32'h0, r);
    chk("ctrl reset", `IAIP_CTRL_RST, r);
    apb(1'b0, 12'h040, 32'h0, r);
    chk("unmapped data", 32'h0, r);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test registers done");
    for (int k = 0; k < 6; k++) begin
      len = (k < 3) ? 4 : 3;
      if (k == 3) apb(1'b1, `IAIP_REG_CTRL, 32'h66, r);
      rv = {$urandom(), $urandom()};
      @(posedge CORE_CLK);
      {PORT_CHANNEL_A_STATE, PORT_CHANNEL_B_STATE, PORT_SENSOR_SHORT_FLAG,
       CHAN_A_FAULT_FLAG, CHAN_B_FAULT_FLAG, SENSOR_SUPPLY_LOW_FLAG,
       ACTUATOR_SUPPLY_LOW_FLAG} <= rv[41:0];
      for (int i = 0; i < 5; i++) begin
        iaip_scanner_i.get(i[3:0], b);
        chk("image byte", {24'h0, mdl(i, len)}, {24'h0, b});
      end
      chk("length", len, {28'h0, IMG_LENGTH});
    end
    apb(1'b0, `IAIP_REG_IMAGE_LO, 32'h0, r);
    chk("image lo", {mdl(3, 4), mdl(2, 4), mdl(1, 4), mdl(0, 4)}, r);
    apb(1'b0, `IAIP_REG_IMAGE_HI, 32'h0, r);
    chk("image hi", 32'h0, r);
    $display("test images done");
    for (int k = 0; k < 4; k++) begin
      rv[15:0] = (k == 0) ? 16'hffff : $urandom();
      iaip_scanner_i.put(rv[15:0]);
      chk("target", {16'h0, rv[15:0]}, {16'h0, CHAN_TARGET});
    end
    apb(1'b0, `IAIP_REG_TARGET, 32'h0, r);
    chk("target readback", {16'h0, rv[15:0]}, r);
    $display("test targets done");
    apb(1'b1, `IAIP_REG_IRQ_CLR, 32'hf, r);
    apb(1'b1, `IAIP_REG_IRQ_EN, 32'h1, r);
    @(negedge CORE_CLK) chk("irq idle", 32'h0, {31'h0, IRQ});
    @(posedge CORE_CLK) PORT_CHANNEL_A_STATE <= ~PORT_CHANNEL_A_STATE;
    repeat (8) @(negedge CORE_CLK);
    chk("irq raised", 32'h1, {31'h0, IRQ});
    apb(1'b0, `IAIP_REG_IRQ_STAT, 32'h0, r);
    chk("irq status", 32'h1, {31'h0, r[0]});
    apb(1'b1, `IAIP_REG_IRQ_EN, 32'h0, r);
    @(negedge CORE_CLK) chk("irq masked", 32'h0, {31'h0, IRQ});
    apb(1'b1, `IAIP_REG_IRQ_CLR, 32'h1, r);
    apb(1'b1, `IAIP_REG_IRQ_EN, 32'h1, r);
    @(negedge CORE_CLK) chk("irq cleared", 32'h0, {31'h0, IRQ});
    apb(1'b1, `IAIP_REG_CTRL, 32'h12, r);
    apb(1'b0, `IAIP_REG_STATUS, 32'h0, r);
    chk("status bad instance", 32'h130, r);
    apb(1'b0, `IAIP_REG_IRQ_STAT, 32'h0, r);
    chk("irq bad instance", 32'h8, r);
    $display("test interrupt done");
    print_verdict;
  end
endmodule
bind iaip_packer iaip_sva #(.VARIANT(VARIANT)) iaip_sva_i (.*);
